/* src/pacr_pkg.sv */
// package for the panel adjust command register bank: command codes,
// parameter field positions, reset values and timing constants.
// assumes a single 100 MHz system clock shared by all users.
`default_nettype none

package pacr_pkg;

    // ***********************************************
    // command codes
    // ***********************************************
    localparam logic [7:0] PACR_CMD_ADJ4 = 8'hF8;
    localparam logic [7:0] PACR_CMD_ADJ5 = 8'hF9;
    localparam logic [7:0] PACR_CMD_RDBK = 8'hFB;
    localparam logic [7:0] PACR_CMD_ADJ6 = 8'hFC;
    localparam logic [7:0] PACR_CMD_ADJ7 = 8'hFF;
    localparam logic [7:0] PACR_CMD_ADJ3 = 8'hF7;

    // ***********************************************
    // reset values
    // ***********************************************
    localparam logic [7:0] PACR_RST_ADJ4_P1 = 8'h21;
    localparam logic [7:0] PACR_RST_ADJ4_P2 = 8'h04;
    localparam logic [7:0] PACR_RST_ADJ5 = 8'h00;
    localparam logic [7:0] PACR_RST_RDBK = 8'h00;
    localparam logic [7:0] PACR_RST_ADJ6_P1 = 8'h00;
    localparam logic [7:0] PACR_RST_ADJ6_P2 = 8'h05;
    localparam logic [7:0] PACR_RST_ADJ7 = 8'h42;
    localparam logic [7:0] PACR_RST_ADJ3_P4 = 8'h82;

    // ***********************************************
    // field positions
    // ***********************************************
    localparam int PACR_BIT_DITHER = 0;
    localparam int PACR_BIT_GAMMA3 = 1;
    localparam int PACR_BIT_CHOP_OPT = 3;
    localparam int PACR_BIT_RD_EN = 7;
    localparam int PACR_IDX_MSB = 3;
    localparam int PACR_NOWI_MSB = 4;
    localparam int PACR_BIT_AXIS_EN = 7;
    localparam int PACR_BIT_DSI18 = 7;
    localparam logic [7:0] PACR_MASK_ADJ5 = 8'h08;
    localparam logic [7:0] PACR_MASK_RDBK = 8'h8F;
    localparam logic [7:0] PACR_MASK_ADJ6_P2 = 8'h1F;
    localparam logic [7:0] PACR_MASK_ADJ7 = 8'h80;
    localparam logic [7:0] PACR_MASK_ADJ4_P2 = 8'h03;

    // ***********************************************
    // timing
    // ***********************************************
    localparam int PACR_NOWI_MAX_CODE = 16;
    localparam logic [3:0] PACR_PARAM_LAST = 4'hF;

    // decoder states, one-hot
    typedef enum logic [2:0] {
        PACR_ST_IDLE = 3'b001,
        PACR_ST_PARAM = 3'b010,
        PACR_ST_READ = 3'b100
    } pacr_state_t;

endpackage : pacr_pkg

`default_nettype wire

/* src/pacr_top.sv */
// panel adjust command register bank: decodes command and parameter bytes
// from the host command port, holds the adjust settings and serves the
// one-shot armed readback of an extended command parameter.
// assumes host pins are synchronous to clk_sys; chopper, gamma and colour
// datapaths live elsewhere and consume the outputs below.
`default_nettype none

module pacr_top #(
    parameter int NOWI_W = 5
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic cmd_data_select,
    input wire logic write_strobe_n,
    input wire logic read_strobe_n,
    input wire logic [7:0] data_in,
    input wire logic [1:0] chopper_sel,
    output logic [7:0] data_out,
    output logic data_oe,
    output logic gamma3_en,
    output logic dither_en,
    output logic chopper_opt,
    output logic [1:0] chopper_mode,
    output logic chopper_frame_mode,
    output logic readback_armed,
    output logic [3:0] readback_param_index,
    output logic [NOWI_W-1:0] gate_nonoverlap_time,
    output logic [NOWI_W-1:0] gate_nonoverlap_cycles,
    output logic color_axis_enhance_en,
    output logic dsi_loose_rgb666
);
    import pacr_pkg::*;

    // ***********************************************
    // state
    // ***********************************************
    typedef struct packed {
        pacr_state_t st;
        logic [7:0] cmd;
        logic [3:0] pidx;
        // strobe levels seen at the last edge, for edge detection
        logic wr_d;
        logic rd_d;
        logic [7:0] adj4_p1;
        logic [7:0] adj4_p2;
        logic [7:0] adj5;
        logic [7:0] rdbk;
        logic [7:0] adj6_p1;
        logic [7:0] adj6_p2;
        logic [7:0] adj7;
        logic [7:0] adj3_p4;
        // readback byte and its drive enable toward the host
        logic [7:0] dout;
        logic doe;
        logic [1:0] chop_mode;
        logic chop_frame;
        logic [NOWI_W-1:0] nowi_cyc;
    } pacr_regs_t;

    pacr_regs_t state_reg;
    pacr_regs_t state_next;

    logic wr_rise;
    logic rd_fall;
    logic rd_rise;
    logic [7:0] par_byte;

    // ***********************************************
    // strobe edges
    // ***********************************************
    // history resets high, the idle level, so no false edge follows reset
    assign wr_rise = write_strobe_n && !state_reg.wr_d;
    assign rd_fall = !read_strobe_n && state_reg.rd_d;
    assign rd_rise = read_strobe_n && !state_reg.rd_d;

    // ***********************************************
    // parameter lookup for readback
    // ***********************************************
    // index n counts from zero, the first parameter after the command byte
    function automatic logic [7:0] param_of(input logic [7:0] c, input logic [3:0] n);
        logic [7:0] v;
        // parameter numbers beyond the command's length read as zero
        v = 8'h00;
        case (c)
            PACR_CMD_ADJ4: begin
                if (n == 4'h0) begin
                    v = state_reg.adj4_p1;
                end else if (n == 4'h1) begin
                    v = state_reg.adj4_p2;
                end
            end
            PACR_CMD_ADJ5: begin
                if (n == 4'h0) begin
                    v = state_reg.adj5;
                end
            end
            PACR_CMD_RDBK: begin
                if (n == 4'h0) begin
                    v = state_reg.rdbk;
                end
            end
            PACR_CMD_ADJ6: begin
                if (n == 4'h0) begin
                    v = state_reg.adj6_p1;
                end else if (n == 4'h1) begin
                    v = state_reg.adj6_p2;
                end
            end
            PACR_CMD_ADJ7: begin
                if (n == 4'h0) begin
                    v = state_reg.adj7;
                end
            end
            PACR_CMD_ADJ3: begin
                // only the fourth parameter is held; the fixed first three read as zero
                if (n == 4'h3) begin
                    v = state_reg.adj3_p4;
                end
            end
            default: begin
                v = 8'h00;
            end
        endcase
        return v;
    endfunction : param_of

    // fixed bits are kept as written except where the ADJ5, RDBK and ADJ6 second-byte masks drop them; only the control fields steer logic
    assign par_byte = data_in;

    // ***********************************************
    // next state
    // ***********************************************
    always_comb begin
        state_next = state_reg;
        state_next.wr_d = write_strobe_n;
        state_next.rd_d = read_strobe_n;
        // no operating-mode gating: accepted in sleep, idle and partial alike
        if (wr_rise) begin
            if (!cmd_data_select) begin
                state_next.cmd = data_in;
                state_next.pidx = 4'h0;
                state_next.st = (state_reg.rdbk[PACR_BIT_RD_EN]) ? PACR_ST_READ
                                                                  : PACR_ST_PARAM;
            end else if (state_reg.st == PACR_ST_PARAM) begin
                // bytes after a command sent while armed are never stored
                case (state_reg.cmd)
                    PACR_CMD_ADJ4: begin
                        if (state_reg.pidx == 4'h0) begin
                            state_next.adj4_p1 = par_byte;
                        end else if (state_reg.pidx == 4'h1) begin
                            state_next.adj4_p2 = par_byte;
                        end
                    end
                    PACR_CMD_ADJ5: begin
                        if (state_reg.pidx == 4'h0) begin
                            // only the scheme bit is kept
                            state_next.adj5 = par_byte & PACR_MASK_ADJ5;
                        end
                    end
                    PACR_CMD_RDBK: begin
                        if (state_reg.pidx == 4'h0) begin
                            // fixed-zero bits between the enable and the index are dropped
                            state_next.rdbk = par_byte & PACR_MASK_RDBK;
                        end
                    end
                    PACR_CMD_ADJ6: begin
                        if (state_reg.pidx == 4'h0) begin
                            state_next.adj6_p1 = par_byte;
                        end else if (state_reg.pidx == 4'h1) begin
                            state_next.adj6_p2 = par_byte & PACR_MASK_ADJ6_P2;
                        end
                    end
                    PACR_CMD_ADJ7: begin
                        if (state_reg.pidx == 4'h0) begin
                            state_next.adj7 = par_byte;
                        end
                    end
                    PACR_CMD_ADJ3: begin
                        // the first three parameters are fixed patterns and are not kept
                        if (state_reg.pidx == 4'h3) begin
                            state_next.adj3_p4 = par_byte;
                        end
                    end
                    default: begin
                    end
                endcase
                // saturate so a long burst never wraps back onto a stored slot
                if (state_reg.pidx != PACR_PARAM_LAST) begin
                    state_next.pidx = state_reg.pidx + 4'h1;
                end
            end
        end
        // armed read: drive the selected parameter during the read strobe
        case (state_reg.st)
            PACR_ST_IDLE: begin
                state_next.doe = 1'b0;
            end
            PACR_ST_PARAM: begin
                state_next.doe = 1'b0;
            end
            PACR_ST_READ: begin
                if (rd_fall) begin
                    state_next.dout = param_of(state_reg.cmd,
                                               state_reg.rdbk[PACR_IDX_MSB:0]);
                    state_next.doe = 1'b1;
                end
                if (rd_rise && state_reg.doe) begin
                    // one arming serves one read; host must rearm for the next
                    state_next.doe = 1'b0;
                    state_next.rdbk[PACR_BIT_RD_EN] = 1'b0;
                    state_next.st = PACR_ST_IDLE;
                end
            end
            default: begin
                state_next.st = PACR_ST_IDLE;
                state_next.doe = 1'b0;
            end
        endcase
        // chopper select registered straight through as the chopper mode
        state_next.chop_mode = chopper_sel;
        // registered so mode and scheme move on the same edge
        state_next.chop_frame = state_reg.adj5[PACR_BIT_CHOP_OPT];
        // codes 0 and above 16 are undefined; clamp to the legal range
        // the gate timer counts this many periods, so a zero count must never reach it
        if (state_reg.adj6_p2[PACR_NOWI_MSB:0] == 5'h00) begin
            state_next.nowi_cyc = NOWI_W'(1);
        end else if (state_reg.adj6_p2[PACR_NOWI_MSB:0] > 5'(PACR_NOWI_MAX_CODE)) begin
            state_next.nowi_cyc = NOWI_W'(PACR_NOWI_MAX_CODE);
        end else begin
            state_next.nowi_cyc = NOWI_W'(state_reg.adj6_p2[PACR_NOWI_MSB:0]);
        end
    end

    // ***********************************************
    // registers
    // ***********************************************
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            // every setting returns to its power-on default
            state_reg.st <= PACR_ST_IDLE;
            state_reg.cmd <= 8'h00;
            state_reg.pidx <= 4'h0;
            state_reg.wr_d <= 1'b1;
            state_reg.rd_d <= 1'b1;
            state_reg.adj4_p1 <= PACR_RST_ADJ4_P1;
            state_reg.adj4_p2 <= PACR_RST_ADJ4_P2;
            state_reg.adj5 <= PACR_RST_ADJ5;
            state_reg.rdbk <= PACR_RST_RDBK;
            state_reg.adj6_p1 <= PACR_RST_ADJ6_P1;
            state_reg.adj6_p2 <= PACR_RST_ADJ6_P2;
            state_reg.adj7 <= PACR_RST_ADJ7;
            state_reg.adj3_p4 <= PACR_RST_ADJ3_P4;
            state_reg.dout <= 8'h00;
            state_reg.doe <= 1'b0;
            state_reg.chop_mode <= 2'h0;
            state_reg.chop_frame <= 1'b0;
            state_reg.nowi_cyc <= NOWI_W'(PACR_RST_ADJ6_P2);
        end else begin
            state_reg <= state_next;
        end
    end

    // ***********************************************
    // outputs, all straight from flip-flops
    // ***********************************************
    // readback port toward the host
    assign data_out = state_reg.dout;
    assign data_oe = state_reg.doe;

    // ***********************************************
    // settings toward the gamma, chopper, gate, colour and DSI logic, and readback status
    // ***********************************************
    assign gamma3_en = state_reg.adj4_p2[PACR_BIT_GAMMA3];
    assign dither_en = state_reg.adj4_p2[PACR_BIT_DITHER];
    assign chopper_opt = state_reg.adj5[PACR_BIT_CHOP_OPT];
    assign chopper_mode = state_reg.chop_mode;
    assign chopper_frame_mode = state_reg.chop_frame;
    assign readback_armed = state_reg.rdbk[PACR_BIT_RD_EN];
    assign readback_param_index = state_reg.rdbk[PACR_IDX_MSB:0];
    assign gate_nonoverlap_time = NOWI_W'(state_reg.adj6_p2[PACR_NOWI_MSB:0]);
    assign gate_nonoverlap_cycles = state_reg.nowi_cyc;
    assign color_axis_enhance_en = state_reg.adj7[PACR_BIT_AXIS_EN];
    assign dsi_loose_rgb666 = state_reg.adj3_p4[PACR_BIT_DSI18];

endmodule : pacr_top

`default_nettype wire

/* verification/pacr_assertions.sv */
// checker for the adjust register bank, bound to pacr_top
// assumes one clock domain and host pins synchronous to clk_sys
`default_nettype none
module pacr_assertions #(
    parameter int NOWI_W = 5
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic cmd_data_select,
    input wire logic write_strobe_n,
    input wire logic read_strobe_n,
    input wire logic [7:0] data_in,
    input wire logic [1:0] chopper_sel,
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    input wire logic gamma3_en,
    input wire logic dither_en,
    input wire logic chopper_opt,
    input wire logic [1:0] chopper_mode,
    input wire logic chopper_frame_mode,
    input wire logic readback_armed,
    input wire logic [3:0] readback_param_index,
    input wire logic [NOWI_W-1:0] gate_nonoverlap_time,
    input wire logic [NOWI_W-1:0] gate_nonoverlap_cycles,
    input wire logic color_axis_enhance_en,
    input wire logic dsi_loose_rgb666
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    property p_cfg_on_strobe;
        $changed({gamma3_en, dither_en, chopper_opt, gate_nonoverlap_time,
            color_axis_enhance_en, dsi_loose_rgb666})
            |-> $past(write_strobe_n) && !$past(write_strobe_n, 2);
    endproperty
    a_cfg_on_strobe: assert property (p_cfg_on_strobe)
        else $error("setting changed without a write strobe rise");
    property p_arm_on_param;
        $rose(readback_armed) |-> $past(write_strobe_n) && !$past(write_strobe_n, 2)
            && $past(cmd_data_select);
    endproperty
    a_arm_on_param: assert property (p_arm_on_param)
        else $error("readback armed without a parameter write");
    property p_oe_rise;
        $rose(data_oe) |-> $past(readback_armed) && !$past(read_strobe_n);
    endproperty
    a_oe_rise: assert property (p_oe_rise)
        else $error("data driven without armed read");
    property p_oe_release;
        data_oe && read_strobe_n |=> !data_oe;
    endproperty
    a_oe_release: assert property (p_oe_release)
        else $error("data still driven after read strobe rose");
    property p_disarm;
        $fell(data_oe) |-> !readback_armed;
    endproperty
    a_disarm: assert property (p_disarm)
        else $error("arming not consumed by the read");
    property p_oe_idle;
        !readback_armed && !data_oe |=> !data_oe;
    endproperty
    a_oe_idle: assert property (p_oe_idle)
        else $error("data driven while not armed");
    property p_nowi_cycles;
        !$past(sys_rst) |-> gate_nonoverlap_cycles == (($past(gate_nonoverlap_time) == 0)
            ? 1 : ($past(gate_nonoverlap_time) > 16) ? 16 : $past(gate_nonoverlap_time));
    endproperty
    a_nowi_cycles: assert property (p_nowi_cycles)
        else $error("non-overlap cycle count wrong");
    property p_chop_mode;
        !$past(sys_rst) |-> chopper_mode == $past(chopper_sel);
    endproperty
    a_chop_mode: assert property (p_chop_mode)
        else $error("chopper mode does not follow select");
    property p_chop_frame;
        !$past(sys_rst) |-> chopper_frame_mode == $past(chopper_opt);
    endproperty
    a_chop_frame: assert property (p_chop_frame)
        else $error("chopper frame mode does not follow option");
endmodule : pacr_assertions

bind pacr_top pacr_assertions #(.NOWI_W(NOWI_W)) u_pacr_chk (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .cmd_data_select(cmd_data_select),
    .write_strobe_n(write_strobe_n),
    .read_strobe_n(read_strobe_n),
    .data_in(data_in),
    .chopper_sel(chopper_sel),
    .data_out(data_out),
    .data_oe(data_oe),
    .gamma3_en(gamma3_en),
    .dither_en(dither_en),
    .chopper_opt(chopper_opt),
    .chopper_mode(chopper_mode),
    .chopper_frame_mode(chopper_frame_mode),
    .readback_armed(readback_armed),
    .readback_param_index(readback_param_index),
    .gate_nonoverlap_time(gate_nonoverlap_time),
    .gate_nonoverlap_cycles(gate_nonoverlap_cycles),
    .color_axis_enhance_en(color_axis_enhance_en),
    .dsi_loose_rgb666(dsi_loose_rgb666)
);
`default_nettype wire

/* verification/pacr_host_model.sv */
// host model driving the command port of the adjust register bank
// assumes every task call starts just after a rising clk_sys edge
`default_nettype none
module pacr_host_model (
    input wire logic clk_sys,
    output logic cmd_data_select,
    output logic write_strobe_n,
    output logic read_strobe_n,
    output logic [7:0] data_in,
    input wire logic [7:0] data_out,
    input wire logic data_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cmd_data_select = 1'b0;
        write_strobe_n = 1'b1;
        read_strobe_n = 1'b1;
        data_in = 8'h00;
    end
    // byte held until the edge that sees the strobe high, then scrambled a cycle
    // before the next call so no signal is assigned twice in one time step
    task automatic wr(input logic sel, input logic [7:0] b);
        cmd_data_select = sel;
        data_in = b;
        write_strobe_n = 1'b0;
        @(posedge clk_sys);
        #1;
        write_strobe_n = 1'b1;
        @(posedge clk_sys);
        #1;
        data_in = ~b;
        @(posedge clk_sys);
        #1;
    endtask : wr
    task automatic rd(output logic [7:0] d, output logic oe);
        read_strobe_n = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        oe = data_oe;
        d = data_out;
        read_strobe_n = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask : rd
endmodule : pacr_host_model
`default_nettype wire

/* verification/panel_adjust_command_regs_tb_top.sv */
// self-checking bench for the adjust register bank
// assumes pacr_host_model drives the host pins and the checker is bound
`default_nettype none
module panel_adjust_command_regs_tb_top import pacr_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, sys_rst, cmd_data_select, write_strobe_n, read_strobe_n, data_oe, oe;
    logic gamma3_en, dither_en, chopper_opt, chopper_frame_mode, readback_armed;
    logic color_axis_enhance_en, dsi_loose_rgb666;
    logic [7:0] data_in, data_out, rd_byte, r, code;
    logic [1:0] chopper_sel, chopper_mode;
    logic [3:0] readback_param_index;
    logic [4:0] gate_nonoverlap_time, gate_nonoverlap_cycles;
    int fails = 0, samples_checked = 0, seed = 32'hf985, i;
    pacr_top #(.NOWI_W(5)) uut (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .cmd_data_select(cmd_data_select),
        .write_strobe_n(write_strobe_n),
        .read_strobe_n(read_strobe_n),
        .data_in(data_in),
        .chopper_sel(chopper_sel),
        .data_out(data_out),
        .data_oe(data_oe),
        .gamma3_en(gamma3_en),
        .dither_en(dither_en),
        .chopper_opt(chopper_opt),
        .chopper_mode(chopper_mode),
        .chopper_frame_mode(chopper_frame_mode),
        .readback_armed(readback_armed),
        .readback_param_index(readback_param_index),
        .gate_nonoverlap_time(gate_nonoverlap_time),
        .gate_nonoverlap_cycles(gate_nonoverlap_cycles),
        .color_axis_enhance_en(color_axis_enhance_en),
        .dsi_loose_rgb666(dsi_loose_rgb666)
    );
    pacr_host_model host (
        .clk_sys(clk_sys),
        .cmd_data_select(cmd_data_select),
        .write_strobe_n(write_strobe_n),
        .read_strobe_n(read_strobe_n),
        .data_in(data_in),
        .data_out(data_out),
        .data_oe(data_oe)
    );
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : stop_test
    function automatic logic [7:0] exp_cycles(input logic [7:0] c);
        return (c == 8'h00) ? 8'h01 : (c > 8'h10) ? 8'h10 : c;
    endfunction : exp_cycles
    task automatic cmd(input logic [7:0] c, input logic [7:0] p[$]);
        host.wr(1'b0, c);
        foreach (p[k]) host.wr(1'b1, p[k]);
    endtask : cmd
    task automatic defaults;
        chk("gamma", 8'h00, {7'h0, gamma3_en});
        chk("dither", 8'h00, {7'h0, dither_en});
        chk("chop", 8'h00, {7'h0, chopper_opt});
        chk("rdbk", 8'h00, {readback_armed, 3'h0, readback_param_index});
        chk("nowi", 8'h05, {3'h0, gate_nonoverlap_time});
        chk("axis", 8'h00, {7'h0, color_axis_enhance_en});
        chk("dsi", 8'h01, {7'h0, dsi_loose_rgb666});
        chk("cycles", 8'h05, {3'h0, gate_nonoverlap_cycles});
        chk("oe", 8'h00, {7'h0, data_oe});
        chk("dout", 8'h00, data_out);
    endtask : defaults
    task automatic rb(input logic [7:0] c, input logic [3:0] n, input logic [7:0] exp);
        cmd(PACR_CMD_RDBK, '{{4'h8, n}});
        chk("arm", {4'h8, n}, {readback_armed, 3'h0, readback_param_index});
        host.wr(1'b0, c);
        host.rd(rd_byte, oe);
        chk("oe", 8'h01, {7'h0, oe});
        chk("rdbk", exp, rd_byte);
        chk("spent", 8'h00, {7'h0, readback_armed});
        host.rd(rd_byte, oe);
        chk("again", 8'h00, {7'h0, oe});
        cmd(PACR_CMD_RDBK, '{8'h00});
    endtask : rb
    initial begin
        #100000;
        fails++;
        stop_test();
    end
    initial begin
        sys_rst = 1'b1;
        chopper_sel = 2'h0;
        repeat (3) @(posedge clk_sys);
        #1 sys_rst = 1'b0;
        defaults();
        for (i = 0; i < 24; i++) begin
            r = 8'($random(seed));
            code = (i < 18) ? 8'(i) : {3'h0, r[4:0]};
            chopper_sel = r[5:4];
            // trailing bytes beyond a command's length and unknown commands must be dropped
            cmd(PACR_CMD_ADJ4, '{PACR_RST_ADJ4_P1, {6'h01, r[1:0]}, 8'hFF});
            cmd(PACR_CMD_ADJ5, '{{4'h0, r[3], 3'h0}});
            cmd(PACR_CMD_ADJ6, '{8'h00, code});
            cmd(PACR_CMD_ADJ7, '{{r[7], 7'h42}});
            cmd(PACR_CMD_ADJ3, '{8'hA9, 8'h51, 8'h2C, {r[6], 7'h02}});
            cmd(8'hF3, '{8'hFF, 8'hFF});
            chk("gamma", {7'h0, r[1]}, {7'h0, gamma3_en});
            chk("dither", {7'h0, r[0]}, {7'h0, dither_en});
            chk("chop", {7'h0, r[3]}, {7'h0, chopper_opt});
            chk("nowi", {3'h0, code[4:0]}, {3'h0, gate_nonoverlap_time});
            chk("cycles", exp_cycles({3'h0, code[4:0]}), {3'h0, gate_nonoverlap_cycles});
            chk("axis", {7'h0, r[7]}, {7'h0, color_axis_enhance_en});
            chk("dsi", {7'h0, r[6]}, {7'h0, dsi_loose_rgb666});
            chk("mode", {6'h0, chopper_sel}, {6'h0, chopper_mode});
            chk("frame", {7'h0, r[3]}, {7'h0, chopper_frame_mode});
        end
        rb(PACR_CMD_ADJ4, 4'h0, PACR_RST_ADJ4_P1);
        rb(PACR_CMD_ADJ4, 4'h1, {6'h01, r[1:0]});
        rb(PACR_CMD_ADJ5, 4'h0, {4'h0, r[3], 3'h0});
        rb(PACR_CMD_ADJ6, 4'h1, {3'h0, code[4:0]});
        rb(PACR_CMD_ADJ7, 4'h0, {r[7], 7'h42});
        rb(PACR_CMD_ADJ6, 4'hF, 8'h00);
        rb(PACR_CMD_ADJ3, 4'h3, {r[6], 7'h02});
        rb(PACR_CMD_RDBK, 4'h0, 8'h80);
        cmd(PACR_CMD_RDBK, '{8'h83});
        sys_rst = 1'b1;
        @(posedge clk_sys);
        #1 sys_rst = 1'b0;
        defaults();
        stop_test();
    end
endmodule : panel_adjust_command_regs_tb_top
`default_nettype wire
